// [hw/rx_ts_regs.svh]
`ifndef RX_TS_REGS_SVH
`define RX_TS_REGS_SVH
`define WIDE_TS_W       96
`define NARROW_TS_W     64
`define RX_LANE_CNT     4
`define TX_LANE_CNT     4
`define VLANE_CNT       4
`define SERIAL_MBPS     10312.5
`define VLANE_PER_SER   2
`endif

// [hw/rx_ts_pkg.sv]
`default_nettype none
package rx_ts_pkg;
  typedef logic [95:0] wide_time_t;
  typedef logic [63:0] narrow_time_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HELD = 2'b10
  } cap_state_t;
endpackage
`default_nettype wire

// [hw/rx_arrival_stamp.sv]
// Operation
// R1: drive 96-bit arrival timestamp for every received packet.
// R2: valid 96-bit timestamp in the same cycle as client start of packet.
// R3: each strobe marks its timestamp's valid cycle, coincides with start.
// R4: drive 64-bit arrival time-of-day for every received packet.
// R5: valid 64-bit time in the same cycle as client start of packet.
// R6: timestamp outputs and strobes exist only when format option enabled; here the ports always exist and are held at zero when disabled.
// R7: receive-ready asserted only when all receive lanes are aligned.
// R8: transmit-lanes-stable asserted only when all transmit lanes aligned.
// R9: virtual lanes zero and one share serial lane zero at 10.3125 Gbps.
// R10: capture time-of-day at link start, hold until client start.
`timescale 1ns/1ps
`default_nettype none
`include "rx_ts_regs.svh"
module rx_arrival_stamp
  import rx_ts_pkg::*;
#(
  parameter bit EN_WIDE   = 1'b1,
  parameter bit EN_NARROW = 1'b1
) (
  input  wire logic                      ref_clk_i,
  input  wire logic                      reset_i,
  input  wire logic [`WIDE_TS_W-1:0]     time_of_day_wide_i,
  input  wire logic [`NARROW_TS_W-1:0]   time_of_day_narrow_i,
  input  wire logic                      link_sop_i,
  input  wire logic                      client_sop_i,
  input  wire logic [`RX_LANE_CNT-1:0]   rx_lane_aligned_i,
  input  wire logic [`TX_LANE_CNT-1:0]   tx_lane_aligned_i,
  input  wire logic [`VLANE_CNT-1:0]     vlane_bit_i,
  output logic                           client_sop_o,
  output logic [`WIDE_TS_W-1:0]          rx_arrival_time_wide_o,
  output logic                           rx_arrival_time_wide_strobe_o,
  output logic [`NARROW_TS_W-1:0]        rx_arrival_time_narrow_o,
  output logic                           rx_arrival_time_narrow_strobe_o,
  output logic                           rx_ready_o,
  output logic                           tx_lanes_stable_o,
  output logic [`VLANE_CNT/`VLANE_PER_SER-1:0] serial_lane_o
);

  cap_state_t   state_r;
  cap_state_t   state_nxt;
  wide_time_t   wide_hold_r;
  narrow_time_t narrow_hold_r;
  logic [`VLANE_CNT/`VLANE_PER_SER-1:0] mux_sel_r;
  wire logic [`VLANE_CNT/`VLANE_PER_SER-1:0] serial_nxt;
  // checks skip the edge that leaves reset; the design already updates normally there
  logic         rst_dly_r;

  function automatic logic lanes_all_up(input logic [`RX_LANE_CNT-1:0] lanes);
    return &lanes;
  endfunction

  wire logic   rx_all_up = lanes_all_up(rx_lane_aligned_i);
  wire logic   tx_all_up = lanes_all_up(tx_lane_aligned_i);

  // a same-cycle link start and client start means zero pipeline latency
  wire logic   take_live = link_sop_i && client_sop_i;
  // single-entry hold: a second link start before its client start wins
  wire logic   hold_load = link_sop_i;
  wire wide_time_t   wide_src   = take_live ? time_of_day_wide_i   : wide_hold_r;
  wire narrow_time_t narrow_src = take_live ? time_of_day_narrow_i : narrow_hold_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (link_sop_i && !client_sop_i) begin
          state_nxt = ST_HELD;
        end
      end
      ST_HELD: begin
        if (client_sop_i && !link_sop_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r       <= ST_IDLE;
      wide_hold_r   <= '0;
      narrow_hold_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (hold_load) begin
        wide_hold_r   <= time_of_day_wide_i; // R10
        narrow_hold_r <= time_of_day_narrow_i; // R10
      end
    end
  end

  // client start is re-registered so stamp and start leave together
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      client_sop_o                    <= 1'b0;
      rx_arrival_time_wide_o          <= '0;
      rx_arrival_time_wide_strobe_o   <= 1'b0;
      rx_arrival_time_narrow_o        <= '0;
      rx_arrival_time_narrow_strobe_o <= 1'b0;
    end else begin
      client_sop_o <= client_sop_i;
      if (client_sop_i) begin
        rx_arrival_time_wide_o   <= EN_WIDE ? wide_src : '0; // R1 R2 R6
        rx_arrival_time_narrow_o <= EN_NARROW ? narrow_src : '0; // R4 R5 R6
      end
      rx_arrival_time_wide_strobe_o   <= EN_WIDE && client_sop_i; // R3 R6
      rx_arrival_time_narrow_strobe_o <= EN_NARROW && client_sop_i; // R3 R6
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_ready_o        <= 1'b0;
      tx_lanes_stable_o <= 1'b0;
      mux_sel_r         <= '0;
      serial_lane_o     <= '0;
      rst_dly_r         <= 1'b1;
    end else begin
      rx_ready_o        <= rx_all_up; // R7
      tx_lanes_stable_o <= tx_all_up; // R8
      mux_sel_r         <= ~mux_sel_r;
      serial_lane_o     <= serial_nxt; // R9
      rst_dly_r         <= 1'b0;
    end
  end

  // two virtual lanes time-share each serial lane, alternating per cycle
  genvar g;
  generate
    for (g = 0; g < `VLANE_CNT/`VLANE_PER_SER; g++) begin : g_ser
      assign serial_nxt[g] = mux_sel_r[g] ? vlane_bit_i[2*g+1] : vlane_bit_i[2*g]; // R9
    end
  endgenerate

  AST_WIDE_STROBE_SOP: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    EN_WIDE |-> (rx_arrival_time_wide_strobe_o == client_sop_o))
    else $error("wide strobe not aligned with start");
  AST_NARROW_STROBE_SOP: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    EN_NARROW |-> (rx_arrival_time_narrow_strobe_o == client_sop_o))
    else $error("narrow strobe not aligned with start");
  AST_WIDE_LIVE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R2
    (EN_WIDE && link_sop_i && client_sop_i) |=> rx_arrival_time_wide_o == $past(time_of_day_wide_i))
    else $error("wide stamp wrong");
  AST_NARROW_HELD: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R10
    (EN_NARROW && link_sop_i && !client_sop_i) ##1 (client_sop_i && !link_sop_i)
    |=> rx_arrival_time_narrow_o == $past(time_of_day_narrow_i, 2))
    else $error("narrow held stamp wrong");
  AST_WIDE_OFF: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    !EN_WIDE |-> !rx_arrival_time_wide_strobe_o)
    else $error("wide strobe while disabled");
  AST_NARROW_STABLE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R5
    !client_sop_i |=> $stable(rx_arrival_time_narrow_o))
    else $error("narrow stamp moved without start");
  AST_RX_READY: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
    rx_ready_o |-> &$past(rx_lane_aligned_i))
    else $error("rx ready without alignment");
  AST_TX_STABLE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R8
    !(&tx_lane_aligned_i) |=> !tx_lanes_stable_o)
    else $error("tx stable without alignment");
  AST_SERIAL_MUX: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R9
    ##1 serial_lane_o[0] == ($past(mux_sel_r[0]) ? $past(vlane_bit_i[1]) : $past(vlane_bit_i[0])))
    else $error("serial lane zero mux wrong");
  AST_SERIAL_MUX_HI: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R9
    ##1 serial_lane_o[1] == ($past(mux_sel_r[1]) ? $past(vlane_bit_i[3]) : $past(vlane_bit_i[2])))
    else $error("serial lane one mux wrong");
  AST_LANE_TOGGLE: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R9
    ##1 mux_sel_r[0] != $past(mux_sel_r[0]))
    else $error("serial lane select did not alternate");

  AST_NARROW_LIVE: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R5
    (EN_NARROW && link_sop_i && client_sop_i) |=> rx_arrival_time_narrow_o == $past(time_of_day_narrow_i))
    else $error("narrow stamp wrong");
  AST_WIDE_HELD: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R10
    (EN_WIDE && link_sop_i && !client_sop_i) ##1 (client_sop_i && !link_sop_i)
    |=> rx_arrival_time_wide_o == $past(time_of_day_wide_i, 2))
    else $error("wide held stamp wrong");
  AST_HOLD_LATEST: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R10
    (EN_NARROW && link_sop_i && !client_sop_i) ##1 (link_sop_i && !client_sop_i)
    ##1 (client_sop_i && !link_sop_i) |=> rx_arrival_time_narrow_o == $past(time_of_day_narrow_i, 2))
    else $error("second link start did not replace hold");
  AST_WIDE_STABLE: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R1
    !client_sop_i |=> $stable(rx_arrival_time_wide_o))
    else $error("wide stamp moved without start");

  AST_SOP_FOLLOWS: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R3
    ##1 client_sop_o == $past(client_sop_i))
    else $error("client start not passed through");
  AST_WIDE_STROBE_RISE: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R3
    (EN_WIDE && client_sop_i) |=> rx_arrival_time_wide_strobe_o)
    else $error("wide strobe missing after start");
  AST_NARROW_STROBE_RISE: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R3
    (EN_NARROW && client_sop_i) |=> rx_arrival_time_narrow_strobe_o)
    else $error("narrow strobe missing after start");
  AST_STROBES_TOGETHER: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
    (EN_WIDE && EN_NARROW) |-> (rx_arrival_time_wide_strobe_o == rx_arrival_time_narrow_strobe_o))
    else $error("strobes out of step");

  AST_NARROW_OFF: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    !EN_NARROW |-> !rx_arrival_time_narrow_strobe_o)
    else $error("narrow strobe while disabled");
  AST_WIDE_ZERO_OFF: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    !EN_WIDE |-> (rx_arrival_time_wide_o == '0))
    else $error("wide stamp while disabled");
  AST_NARROW_ZERO_OFF: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
    !EN_NARROW |-> (rx_arrival_time_narrow_o == '0))
    else $error("narrow stamp while disabled");

  AST_RX_READY_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R7
    (&rx_lane_aligned_i) |=> rx_ready_o)
    else $error("rx ready missing after alignment");
  AST_TX_STABLE_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R8
    (&tx_lane_aligned_i) |=> tx_lanes_stable_o)
    else $error("tx stable missing after alignment");

  AST_HELD_ON_LINK: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R10
    (link_sop_i && !client_sop_i) |=> (state_r == ST_HELD))
    else $error("hold not pending after link start");
  AST_IDLE_ON_CLIENT: assert property (@(posedge ref_clk_i) disable iff (reset_i || rst_dly_r) // R10
    (client_sop_i && !link_sop_i) |=> (state_r == ST_IDLE))
    else $error("hold still pending after client start");

endmodule
`default_nettype wire

// [verification/rx_client_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_client_sink (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        sop_i,
  output logic [15:0]      pkt_cnt_o
);
  // client only counts starts; stamps are taken as they stand
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) pkt_cnt_o <= 16'h0000;
    else if (sop_i) pkt_cnt_o <= pkt_cnt_o + 16'h0001;
  end
endmodule
`default_nettype wire

// [verification/rx_arrival_stamp_test.sv]
`timescale 1ns/1ps
`default_nettype none
module rx_arrival_stamp_test;
  import rx_ts_pkg::*;
  logic ref_clk_i = 0, reset_i = 1, lsop = 0, csop = 0, sop, ws, ns, rdy, txs, tg;
  logic [3:0] rxa = 0, txa = 0, vl = 0;
  logic [1:0] ser, e_ser;
  wide_time_t tw = 0, ow, hw, ew;
  narrow_time_t tn = 0, on, hn, en;
  logic [15:0] cnt, e_cnt;
  logic e_sop, e_rdy, e_tx;
  wide_time_t ow_off;
  narrow_time_t on_off;
  logic ws_off, ns_off;
  int miscompares = 0, n_checks = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  rx_arrival_stamp DUT (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .time_of_day_wide_i(tw),
    .time_of_day_narrow_i(tn), .link_sop_i(lsop), .client_sop_i(csop), .rx_lane_aligned_i(rxa),
    .tx_lane_aligned_i(txa), .vlane_bit_i(vl), .client_sop_o(sop), .rx_arrival_time_wide_o(ow),
    .rx_arrival_time_wide_strobe_o(ws), .rx_arrival_time_narrow_o(on),
    .rx_arrival_time_narrow_strobe_o(ns), .rx_ready_o(rdy), .tx_lanes_stable_o(txs),
    .serial_lane_o(ser));
  rx_client_sink sink (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .sop_i(sop), .pkt_cnt_o(cnt));
  // both formats built out: strobes and stamps must stay zero
  rx_arrival_stamp #(.EN_WIDE(1'b0), .EN_NARROW(1'b0)) DUT_OFF (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .time_of_day_wide_i(tw), .time_of_day_narrow_i(tn), .link_sop_i(lsop), .client_sop_i(csop),
    .rx_lane_aligned_i(rxa), .tx_lane_aligned_i(txa), .vlane_bit_i(vl), .client_sop_o(),
    .rx_arrival_time_wide_o(ow_off), .rx_arrival_time_wide_strobe_o(ws_off),
    .rx_arrival_time_narrow_o(on_off), .rx_arrival_time_narrow_strobe_o(ns_off), .rx_ready_o(),
    .tx_lanes_stable_o(), .serial_lane_o());
  // reference model sees the same pre-edge inputs as the design
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      {e_sop, e_rdy, e_tx, tg, e_ser, hw, hn, ew, en, e_cnt} = 0;
    end else begin
      e_rdy = &rxa;
      e_tx = &txa;
      e_ser = tg ? {vl[3], vl[1]} : {vl[2], vl[0]};
      tg = ~tg;
      if (lsop) {hw, hn} = {tw, tn};
      // the sink counts the registered start, one edge behind
      e_cnt = e_cnt + 16'(e_sop);
      e_sop = csop;
      if (csop) {ew, en} = {hw, hn};
    end
  end
  task chk_ts(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t stamp got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_fl(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t flag got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge ref_clk_i) begin
    chk_fl(16'({sop, ws, ns}), 16'({3{e_sop}}));
    chk_ts(ow, ew);
    chk_ts(96'(on), 96'(en));
    chk_fl(16'({rdy, txs}), 16'({e_rdy, e_tx}));
    chk_fl(16'(ser), 16'(e_ser));
    chk_fl(cnt, e_cnt);
    chk_ts(ow_off, 96'h0);
    chk_ts(96'(on_off), 96'h0);
    chk_fl(16'({ws_off, ns_off}), 16'h0000);
  end
  task wrap_up;
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(71));
    repeat (9) @(posedge ref_clk_i);
    for (int i = 0; i < 3000; i++) begin
      @(posedge ref_clk_i);
      // second reset mid-run; traffic kept off around it
      reset_i <= (i >= 1500 && i < 1503);
      tw <= {$urandom, $urandom, $urandom};
      tn <= {$urandom, $urandom};
      lsop <= ($urandom % 4 == 0) && !(i >= 1499 && i < 1504);
      csop <= ($urandom % 3 == 0) && !(i >= 1499 && i < 1504);
      rxa <= ($urandom % 3) ? 4'hf : 4'($urandom);
      txa <= ($urandom % 3) ? 4'hf : 4'($urandom);
      vl <= 4'($urandom);
    end
    @(posedge ref_clk_i);
    wrap_up();
  end
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
